// File: common/epc_defs.svh
// How it works
// - Selects pick program/erase; protected block does nothing
// - Latch captures only in-range array writes
// - Later array write replaces captured address/data
// - Array read returns latch, captures read address
// - Enable set needs latch and captured address
// - Enable drives charge pump and high voltage
// - Auto timer clears enable itself
// - Auto delay shorter than manual time
// - Clearing enable and latch together clears enable
// - Latch holds while enable is set
// - Control writes while latching need captured array write first
// - Erase scope: byte, block or all unprotected blocks
// - Power-down bit; reset clears control bits
// - Spare control/config bits store without function
// - Config register read-only, loaded after reset
// - Four protect bits, one per 128-byte block
// - Security guards bytes 0x0f0-0x0ff, blocks block and bulk erase
// - Erase ignored in protected blocks
// - Timing from 35 us timebase divider
`ifndef EPC_DEFS_SVH
`define EPC_DEFS_SVH
`define EPC_ARRAY_BASE 32'h0000_0000
`define EPC_ARRAY_LAST 32'h0000_01ff
`define EPC_CTRL_OFF 32'h0000_0200
`define EPC_CFG_OFF 32'h0000_0204
`define EPC_DIV_OFF 32'h0000_0208
`define EPC_STAT_OFF 32'h0000_020c
`define EPC_B_SPARE 7
`define EPC_B_OFF 6
`define EPC_B_RAS1 5
`define EPC_B_RAS0 4
`define EPC_B_LAT 3
`define EPC_B_AUTO 1
`define EPC_B_PGM 0
`define EPC_B_PRTCT 4
`define EPC_CTRL_RST 8'h00
`define EPC_NVCFG_DEF 8'hf0
`define EPC_SECURE_LO 9'h0f0
`define EPC_SECURE_HI 9'h0ff
`define EPC_DIV_DEF 11'h2bc
`define EPC_TB_NS 35000
`define EPC_CLK_NS 50
`define EPC_PGM_TICKS 16'h0064
`define EPC_BYTE_TICKS 16'h0064
`define EPC_BLOCK_TICKS 16'h0064
`define EPC_BULK_TICKS 16'h0064
`define EPC_FALL_CYC 16'h000a
`endif

// File: common/epc_pkg.sv
package epc_pkg;
    typedef enum logic [1:0] {
        EPC_BYTE_PROG = 2'b00,
        EPC_BYTE_ERASE = 2'b01,
        EPC_BLOCK_ERASE = 2'b10,
        EPC_BULK_ERASE = 2'b11
    } epc_mode_t;
    typedef enum logic [1:0] {
        EPC_IDLE = 2'b00,
        EPC_ADDR = 2'b01,
        EPC_RESP = 2'b10
    } epc_bus_t;
endpackage : epc_pkg

// File: hdl/epc_ctrl.sv
// The register offsets and the AXI4-Lite slave port were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "epc_defs.svh"
module epc_ctrl (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] nv_config,
    output logic pump_on,
    output logic [8:0] op_addr,
    output logic [7:0] op_data,
    output epc_pkg::epc_mode_t op_mode,
    output logic op_active,
    output logic op_failed
);
    import epc_pkg::*;

    logic aw_have_q, w_have_q;
    logic [31:0] awaddr_q, wdata_q;
    logic wstrb0_q;
    logic [7:0] ctrl_q, cfg_q;
    logic [10:0] div_q;
    logic [8:0] lat_addr_q;
    logic [7:0] lat_data_q;
    logic lat_valid_q;
    logic [15:0] tb_cnt_q, tick_cnt_q;
    logic fail_q;
    logic [7:0] mem_q [0:511];
    logic cfg_loaded_q;

    // Block number of an array offset
    function automatic logic [1:0] blk_of(input logic [8:0] a);
        blk_of = a[8:7];
    endfunction : blk_of

    // Address lies inside the array window
    function automatic logic in_array(input logic [31:0] a);
        in_array = (a >= `EPC_ARRAY_BASE) && (a <= `EPC_ARRAY_LAST);
    endfunction : in_array

    wire logic wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
    wire logic rd_go = s_axi_arvalid && s_axi_arready;
    wire logic wr_arr = wr_go && in_array(awaddr_q) && wstrb0_q;
    wire logic wr_ctrl = wr_go && awaddr_q == `EPC_CTRL_OFF && wstrb0_q;
    wire logic wr_div = wr_go && awaddr_q == `EPC_DIV_OFF && !ctrl_q[`EPC_B_LAT];
    wire logic rd_arr = rd_go && in_array(s_axi_araddr);
    wire logic lat_on = ctrl_q[`EPC_B_LAT];
    wire logic pgm_on = ctrl_q[`EPC_B_PGM];
    wire epc_mode_t mode = epc_mode_t'(ctrl_q[`EPC_B_RAS1:`EPC_B_RAS0]);
    wire logic secure = !cfg_q[`EPC_B_PRTCT];
    wire logic in_secure = lat_addr_q >= `EPC_SECURE_LO && lat_addr_q <= `EPC_SECURE_HI;
    // Control writes are held off while latching until an array write lands
    wire logic ctrl_ok = !lat_on || lat_valid_q;
    wire logic tb_tick = tb_cnt_q == 16'(div_q) && div_q != 11'h000;
    logic [15:0] limit;

    // Permitted-operation check, per protect and security bits
    logic allowed;
    always_comb begin
        allowed = !cfg_q[blk_of(lat_addr_q)];
        if (secure && in_secure) allowed = 1'b0;
        if (secure && (mode == EPC_BLOCK_ERASE || mode == EPC_BULK_ERASE)) allowed = 1'b0;
        case (mode)
            EPC_BYTE_PROG: limit = `EPC_PGM_TICKS;
            EPC_BYTE_ERASE: limit = `EPC_BYTE_TICKS;
            EPC_BLOCK_ERASE: limit = `EPC_BLOCK_TICKS;
            default: limit = `EPC_BULK_TICKS;
        endcase
    end

    // Write address and data channels, taken in either order
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 32'h0000_0000;
            wdata_q <= 32'h0000_0000;
            wstrb0_q <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
        end else begin
            s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_have_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                awaddr_q <= s_axi_awaddr; // Byte address kept for the array
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb0_q <= s_axi_wstrb[0];
            end
            if (wr_go) s_axi_bvalid <= 1'b1;
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
            end
        end
    end
    assign s_axi_bresp = 2'b00;

    // Read channel, one-cycle answer
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= 2'b00;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
            if (rd_go) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= 2'b00;
                if (in_array(s_axi_araddr)) begin
                    if (lat_on) s_axi_rdata <= {24'h000000, lat_data_q};
                    else if (ctrl_q[`EPC_B_OFF]) s_axi_rdata <= 32'h0000_00ff;
                    else s_axi_rdata <= {24'h000000, mem_q[s_axi_araddr[8:0]]};
                end else if (s_axi_araddr == `EPC_CTRL_OFF) s_axi_rdata <= {24'h000000, ctrl_q};
                else if (s_axi_araddr == `EPC_CFG_OFF) s_axi_rdata <= {24'h000000, cfg_q};
                else if (s_axi_araddr == `EPC_DIV_OFF) s_axi_rdata <= {21'h0, div_q};
                else if (s_axi_araddr == `EPC_STAT_OFF) s_axi_rdata <= {30'h0, fail_q, lat_valid_q};
                else begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= 2'b10;
                end
            end else if (s_axi_rvalid && s_axi_rready) s_axi_rvalid <= 1'b0;
        end
    end

    // Control register with its interlocks
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_q <= `EPC_CTRL_RST;
        end else begin
            if (wr_ctrl && ctrl_ok) begin
                ctrl_q[`EPC_B_SPARE] <= wdata_q[`EPC_B_SPARE];
                ctrl_q[`EPC_B_OFF] <= wdata_q[`EPC_B_OFF];
                ctrl_q[`EPC_B_RAS1:`EPC_B_RAS0] <= wdata_q[`EPC_B_RAS1:`EPC_B_RAS0];
                ctrl_q[`EPC_B_AUTO] <= wdata_q[`EPC_B_AUTO];
                // Latch stays on while enable is set
                ctrl_q[`EPC_B_LAT] <= pgm_on ? 1'b1 : wdata_q[`EPC_B_LAT];
                // Enable needs latching with a captured address
                ctrl_q[`EPC_B_PGM] <= wdata_q[`EPC_B_PGM] && lat_on && lat_valid_q;
            end else if (pgm_on && ctrl_q[`EPC_B_AUTO] && tick_cnt_q >= limit - 16'h0001) begin
                ctrl_q[`EPC_B_PGM] <= 1'b0;
            end
        end
    end

    // Captured address and data while latching
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            lat_addr_q <= 9'h000;
            lat_data_q <= 8'hff;
            lat_valid_q <= 1'b0;
        end else if (!lat_on) begin
            lat_valid_q <= 1'b0;
        end else if (wr_arr && !pgm_on) begin
            lat_addr_q <= awaddr_q[8:0];
            lat_data_q <= wdata_q[7:0];
            lat_valid_q <= 1'b1;
        end else if (rd_arr && !pgm_on) begin
            lat_addr_q <= s_axi_araddr[8:0];
        end
    end

    // 35 us timebase and cycle tick counter
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            tb_cnt_q <= 16'h0000;
            tick_cnt_q <= 16'h0000;
        end else begin
            tb_cnt_q <= (tb_tick || !pgm_on) ? 16'h0001 : tb_cnt_q + 16'h0001;
            if (!pgm_on) tick_cnt_q <= 16'h0000;
            else if (tb_tick) tick_cnt_q <= tick_cnt_q + 16'h0001;
        end
    end

    // Divider and config register, config loaded after reset
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            div_q <= `EPC_DIV_DEF;
            cfg_q <= `EPC_NVCFG_DEF;
            cfg_loaded_q <= 1'b0;
        end else begin
            if (!cfg_loaded_q) begin
                cfg_q <= nv_config;
                cfg_loaded_q <= 1'b1;
            end
            if (wr_div) div_q <= wdata_q[10:0];
        end
    end

    // Array contents, updated when a cycle ends
    wire logic pgm_fall = pgm_on && (ctrl_q[`EPC_B_AUTO] ? tick_cnt_q >= limit - 16'h0001 :
                          (wr_ctrl && ctrl_ok && !wdata_q[`EPC_B_PGM]));
    // Array model comes up erased; its contents do not survive a reset
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < 512; i++) begin
                mem_q[i] <= 8'hff;
            end
        end else if (pgm_fall && allowed && !fail_q) begin
            for (int i = 0; i < 512; i++) begin
                if (mode == EPC_BYTE_PROG && i == int'(lat_addr_q))
                    mem_q[i] <= mem_q[i] & lat_data_q;
                else if ((mode == EPC_BYTE_ERASE && i == int'(lat_addr_q)) ||
                         (mode == EPC_BLOCK_ERASE && i / 128 == int'(blk_of(lat_addr_q)) &&
                          !cfg_q[i / 128]) ||
                         (mode == EPC_BULK_ERASE && !cfg_q[i / 128]))
                    mem_q[i] <= 8'hff;
            end
        end
    end

    // Read during a cycle spoils it
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) fail_q <= 1'b0;
        else if (pgm_on && rd_arr) fail_q <= 1'b1;
        else if (!lat_on) fail_q <= 1'b0;
    end

    // Outputs to the array and pump
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pump_on <= 1'b0;
            op_addr <= 9'h000;
            op_data <= 8'hff;
            op_mode <= EPC_BYTE_PROG;
            op_active <= 1'b0;
            op_failed <= 1'b0;
        end else begin
            pump_on <= pgm_on && lat_on && allowed && !ctrl_q[`EPC_B_OFF];
            op_addr <= lat_addr_q;
            op_data <= lat_data_q;
            op_mode <= mode;
            op_active <= pgm_on;
            op_failed <= fail_q;
        end
    end

    // Enable needs a latched target; latch holds while enabled
    a_pgm_needs_lat: assert property (@(posedge clock) disable iff (!reset_n)
        $rose(pgm_on) |-> $past(lat_on) && $past(lat_valid_q))
        else $error("enable without latch");
    a_pgm_gated: assert property (@(posedge clock) disable iff (!reset_n)
        wr_ctrl && ctrl_ok && !(lat_on && lat_valid_q) |=> !pgm_on)
        else $error("enable set without capture");
    a_lat_holds: assert property (@(posedge clock) disable iff (!reset_n)
        $past(pgm_on) |-> lat_on)
        else $error("latch dropped while enabled");
    a_lat_kept: assert property (@(posedge clock) disable iff (!reset_n)
        wr_ctrl && ctrl_ok && pgm_on |=> lat_on)
        else $error("latch cleared with enable");
    a_ctrl_gated: assert property (@(posedge clock) disable iff (!reset_n)
        wr_ctrl && lat_on && !lat_valid_q |=> $stable(ctrl_q))
        else $error("ctrl write accepted early");

    // Capture of the target address and data
    a_capture_src: assert property (@(posedge clock) disable iff (!reset_n)
        $rose(lat_valid_q) |-> $past(wr_arr))
        else $error("capture without array write");
    a_capture_addr: assert property (@(posedge clock) disable iff (!reset_n)
        wr_arr && lat_on && !pgm_on |=> {23'h0, lat_addr_q} == $past(awaddr_q))
        else $error("write not captured");
    a_rd_capture: assert property (@(posedge clock) disable iff (!reset_n)
        rd_arr && lat_on && !pgm_on && !wr_arr |=> {23'h0, lat_addr_q} == $past(s_axi_araddr))
        else $error("read address not captured");
    a_rd_latched: assert property (@(posedge clock) disable iff (!reset_n)
        rd_arr && lat_on |=> s_axi_rdata[7:0] == $past(lat_data_q))
        else $error("latched read wrong");
    a_lat_clear: assert property (@(posedge clock) disable iff (!reset_n)
        !lat_on |=> !lat_valid_q)
        else $error("capture kept without latch");

    // Pump and high voltage gating
    a_pump_follows: assert property (@(posedge clock) disable iff (!reset_n)
        pump_on |-> $past(pgm_on))
        else $error("pump without enable");
    a_pump_allowed: assert property (@(posedge clock) disable iff (!reset_n)
        !allowed |=> !pump_on)
        else $error("pump on a refused target");
    a_pump_powerdn: assert property (@(posedge clock) disable iff (!reset_n)
        ctrl_q[`EPC_B_OFF] |=> !pump_on)
        else $error("pump on while powered down");
    a_secure_block: assert property (@(posedge clock) disable iff (!reset_n)
        secure && mode == EPC_BULK_ERASE |=> !pump_on)
        else $error("bulk under security");
    a_protect_block: assert property (@(posedge clock) disable iff (!reset_n)
        cfg_q[blk_of(lat_addr_q)] |=> !pump_on)
        else $error("protected block pumped");
    a_auto_clear: assert property (@(posedge clock) disable iff (!reset_n)
        pgm_on && ctrl_q[`EPC_B_AUTO] && !wr_ctrl && tick_cnt_q >= limit - 16'h0001 |=> !pgm_on)
        else $error("auto did not clear");
    a_fail_set: assert property (@(posedge clock) disable iff (!reset_n)
        pgm_on && rd_arr |=> fail_q)
        else $error("read during cycle not flagged");

    // Configuration, timebase and bus handshakes
    a_cfg_steady: assert property (@(posedge clock) disable iff (!reset_n)
        cfg_loaded_q |=> $stable(cfg_q))
        else $error("config changed after load");
    a_div_locked: assert property (@(posedge clock) disable iff (!reset_n)
        lat_on |=> $stable(div_q))
        else $error("divider written while latched");
    a_tick_spaced: assert property (@(posedge clock) disable iff (!reset_n)
        tb_tick && !wr_div && div_q > 11'h001 |=> !tb_tick)
        else $error("timebase ticks too close");
    a_bresp_hold: assert property (@(posedge clock) disable iff (!reset_n)
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    a_rresp_hold: assert property (@(posedge clock) disable iff (!reset_n)
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");

    // Main scenarios
    c_program: cover property (@(posedge clock) disable iff (!reset_n) pump_on && mode == EPC_BYTE_PROG);
    c_erase: cover property (@(posedge clock) disable iff (!reset_n) pump_on && mode == EPC_BLOCK_ERASE);
    c_fail: cover property (@(posedge clock) disable iff (!reset_n) $rose(fail_q));
    c_auto_done: cover property (@(posedge clock) disable iff (!reset_n) $fell(pgm_on) && ctrl_q[`EPC_B_AUTO]);
    c_secure_refused: cover property (@(posedge clock) disable iff (!reset_n) pgm_on && secure && !allowed);
endmodule : epc_ctrl
`default_nettype wire

// File: verification/epc_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
module epc_cpu_model (
    input wire logic clock,
    output logic [31:0] awaddr,
    output logic awvalid,
    input wire logic awready,
    output logic [31:0] wdata,
    output logic wvalid,
    input wire logic wready,
    input wire logic bvalid,
    output logic bready,
    output logic [31:0] araddr,
    output logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    output logic rready
);
    // Idle bus at time zero
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
        {awaddr, wdata, araddr} = 96'h0;
    end

    // One write; released lines flip so stale values never match
    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        @(posedge clock);
        awaddr <= a;
        wdata <= {24'h000000, d};
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(posedge clock);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        awaddr <= ~a;
        wdata <= ~{24'h000000, d};
        @(negedge clock); // Outputs launched at the answer edge have settled
    endtask : wr

    // One read; data and response taken at the rvalid edge
    task automatic rd(input logic [31:0] a, output logic [7:0] d, output logic [1:0] r);
        @(posedge clock);
        araddr <= a;
        {arvalid, rready} <= 2'h3;
        do begin
            @(posedge clock);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata[7:0];
        r = rresp;
        rready <= 1'b0;
        araddr <= ~a;
        @(negedge clock); // Outputs launched at the answer edge have settled
    endtask : rd
endmodule : epc_cpu_model
`default_nettype wire

// File: verification/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "epc_defs.svh"
module tb;
    import epc_pkg::*;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] nv_config = 8'hf8;
    logic [31:0] awaddr, wdata, araddr, rdata;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [1:0] bresp, rresp;
    logic pump_on, op_active, op_failed;
    logic [8:0] op_addr;
    logic [7:0] op_data, v;
    epc_mode_t op_mode;
    int miscompares = 0;
    int num_checks = 0;
    int cyc = 0;

    epc_ctrl i_epc_ctrl (.clock(clock), .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .nv_config(nv_config),
        .pump_on(pump_on), .op_addr(op_addr), .op_data(op_data), .op_mode(op_mode),
        .op_active(op_active), .op_failed(op_failed));
    epc_cpu_model i_epc_cpu_model (.clock(clock), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready));

    // Clock and hang guard
    always #25 clock = ~clock;
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            miscompares++;
            end_of_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic rchk(input logic [31:0] a, input logic [7:0] exp);
        logic [1:0] r;
        i_epc_cpu_model.rd(a, v, r);
        chk(v, exp);
    endtask : rchk

    // Reset with a given nonvolatile value, then a short divider
    task automatic do_reset(input logic [7:0] nv);
        @(posedge clock);
        reset_n <= 1'b0;
        nv_config <= nv;
        repeat (6) @(posedge clock);
        reset_n <= 1'b1;
        repeat (2) @(posedge clock);
        i_epc_cpu_model.wr(`EPC_DIV_OFF, 8'h02);
    endtask : do_reset

    // Auto-terminated cycle, then latch cleared
    task automatic run(input logic [1:0] m, input logic [31:0] a, input logic [7:0] d);
        int n;
        logic [1:0] r;
        n = 0;
        i_epc_cpu_model.wr(`EPC_CTRL_OFF, {2'b00, m, 4'b1010});
        i_epc_cpu_model.wr(a, d);
        i_epc_cpu_model.wr(`EPC_CTRL_OFF, {2'b00, m, 4'b1011});
        do begin
            i_epc_cpu_model.rd(`EPC_CTRL_OFF, v, r);
            n++;
        end while (v[0] !== 1'b0 && n < 400);
        chk(n < 400, 1'b1);
        chk(v, {2'b00, m, 4'b1010});
        i_epc_cpu_model.wr(`EPC_CTRL_OFF, 8'h00);
    endtask : run

    // Manual cycle: wait the mode time, drop enable, wait the fall, drop latch
    task automatic manual(input logic [1:0] m, input logic [31:0] a, input logic [7:0] d, input int t,
                          input logic [7:0] exp);
        i_epc_cpu_model.wr(`EPC_CTRL_OFF, {2'b00, m, 4'b1000});
        i_epc_cpu_model.wr(a, d);
        i_epc_cpu_model.wr(`EPC_CTRL_OFF, {2'b00, m, 4'b1001});
        repeat (t) @(posedge clock);
        chk(pump_on, 1'b1);
        i_epc_cpu_model.wr(`EPC_CTRL_OFF, {2'b00, m, 4'b1000});
        chk(pump_on, 1'b0);
        repeat (`EPC_FALL_CYC) @(posedge clock);
        i_epc_cpu_model.wr(`EPC_CTRL_OFF, 8'h00);
        rchk(a, exp);
    endtask : manual

    task automatic t_reset_regs;
        logic [1:0] r;
        chk({pump_on, op_active, op_data}, 10'h0ff);
        rchk(`EPC_CTRL_OFF, 8'h00);
        rchk(`EPC_CFG_OFF, 8'hf8);
        i_epc_cpu_model.wr(`EPC_CFG_OFF, 8'h05);
        chk(bresp, 2'h0);
        rchk(`EPC_CFG_OFF, 8'hf8);
        i_epc_cpu_model.wr(`EPC_CTRL_OFF, 8'hc0);
        rchk(`EPC_CTRL_OFF, 8'hc0);
        chk(pump_on, 1'b0);
        rchk(32'h0000_0010, 8'hff);
        i_epc_cpu_model.wr(`EPC_CTRL_OFF, 8'h00);
        i_epc_cpu_model.rd(32'h0000_0300, v, r);
        chk(r, 2'h2);
        $display("t_reset_regs done");
    endtask : t_reset_regs

    task automatic t_manual;
        i_epc_cpu_model.wr(`EPC_CTRL_OFF, 8'h08);
        i_epc_cpu_model.wr(`EPC_CTRL_OFF, 8'h09);
        rchk(`EPC_CTRL_OFF, 8'h08);
        chk(pump_on, 1'b0);
        i_epc_cpu_model.wr(`EPC_DIV_OFF, 8'h07);
        rchk(`EPC_DIV_OFF, 8'h02);
        rchk(`EPC_STAT_OFF, 8'h00);
        i_epc_cpu_model.wr(32'h0000_0040, 8'h5a);
        i_epc_cpu_model.wr(32'h0000_0041, 8'ha5);
        chk({op_addr, op_data, op_mode}, {9'h041, 8'ha5, EPC_BYTE_PROG});
        rchk(32'h0000_0041, 8'ha5);
        i_epc_cpu_model.wr(`EPC_CTRL_OFF, 8'h09);
        chk({pump_on, op_active}, 2'h3);
        i_epc_cpu_model.wr(`EPC_CTRL_OFF, 8'h01);
        rchk(`EPC_CTRL_OFF, 8'h09);
        rchk(32'h0000_0041, 8'ha5);
        chk(op_failed, 1'b1);
        i_epc_cpu_model.wr(`EPC_CTRL_OFF, 8'h00);
        rchk(`EPC_CTRL_OFF, 8'h08);
        chk(pump_on, 1'b0);
        i_epc_cpu_model.wr(`EPC_CTRL_OFF, 8'h00);
        rchk(`EPC_CTRL_OFF, 8'h00);
        manual(2'b00, 32'h0000_0050, 8'h0f, 3 * `EPC_PGM_TICKS, 8'h0f);
        manual(2'b01, 32'h0000_0050, 8'h00, 3 * `EPC_BYTE_TICKS, 8'hff);
        $display("t_manual done");
    endtask : t_manual

    task automatic t_modes;
        run(2'b00, 32'h0000_0010, 8'h5a);
        rchk(32'h0000_0010, 8'h5a);
        run(2'b01, 32'h0000_0010, 8'h00);
        rchk(32'h0000_0010, 8'hff);
        run(2'b00, 32'h0000_0030, 8'h3c);
        run(2'b10, 32'h0000_0000, 8'h77);
        rchk(32'h0000_0030, 8'hff);
        run(2'b00, 32'h0000_0110, 8'h00);
        run(2'b11, 32'h0000_0000, 8'h00);
        rchk(32'h0000_0110, 8'hff);
        run(2'b00, 32'h0000_0190, 8'h00);
        rchk(32'h0000_0190, 8'hff);
        run(2'b01, 32'h0000_0190, 8'h00);
        rchk(32'h0000_0190, 8'hff);
        $display("t_modes done");
    endtask : t_modes

    task automatic t_secure;
        do_reset(8'he0);
        run(2'b00, 32'h0000_00f0, 8'h00);
        rchk(32'h0000_00f0, 8'hff);
        run(2'b00, 32'h0000_0020, 8'h00);
        run(2'b11, 32'h0000_0020, 8'h00);
        rchk(32'h0000_0020, 8'h00);
        run(2'b01, 32'h0000_0020, 8'h00);
        rchk(32'h0000_0020, 8'hff);
        $display("t_secure done");
    endtask : t_secure

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_of_test

    // Main sequence
    initial begin
        do_reset(8'hf8);
        t_reset_regs();
        t_manual();
        t_modes();
        t_secure();
        end_of_test();
    end
endmodule : tb
`default_nettype wire
